// ===== dv/sdb_column_engine_tb.sv
// bench for the sdram column engine: mode set over axi4-lite, bursts
// through the controller model, read words gathered while driven.
`timescale 1ns/1ps
`include "sdb_defs.svh"
module sdb_column_engine_tb
   import sdb_pkg::*;
;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic        awready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, bmask, oe_n, drv;
   logic [31:0] rdata;
   logic [15:0] dqi, dqo, rq[$], wd[$], xp[$];
   sdb_cmd_s    cmd;
   int          err_total = 0, checks_done = 0;
   wire  [3:0]  hs = {rvalid, bvalid, arready, awready};

   always #5 aclk = ~aclk;
   always @(posedge aclk) if (oe_n !== 2'b11) begin
      rq.push_back(dqo);
      drv = drv | ~oe_n;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task give_verdict;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_hi(input int k);
      int n;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (hs[k] !== 1'b1 && n < 40);
      if (hs[k] !== 1'b1) begin
         err_total++;
         give_verdict;
      end
   endtask
   task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      wait_hi(0);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      wait_hi(2);
      chk(bresp, er);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      wait_hi(1);
      arvalid <= 1'b0;
      wait_hi(3);
      chk(rdata, e);
      chk(rresp, er);
   endtask
   // mask high byte on beat mb only; mb out of range masks nothing
   task automatic wr_burst(input logic [11:0] a, input int n,
                           input int mb, input bit stp);
      for (int i = 0; i < n; i++)
         i_ctl.cyc(i == 0 ? `SDB_CMD_WR : 4'hF, a,
                   i == mb ? 2'b10 : 2'b00, wd[i]);
      if (stp) i_ctl.stop(2'b00);
      i_ctl.rest(3, 2'b00);
   endtask
   // mask goes up a clock early so it covers the first driven cycle
   task automatic rd_burst(input logic [11:0] a, input int n,
                           input bit stp, input logic [1:0] m);
      i_ctl.rest(1, m);
      rq.delete();
      drv = 2'b00;
      i_ctl.cyc(`SDB_CMD_RD, a, m, ~dqi);
      i_ctl.rest(n - 1, m);
      if (stp) i_ctl.stop(m);
      i_ctl.rest(12, m);
   endtask
   // first driven cycle carries no data, so words start at index one
   task automatic words(input int n, input logic [15:0] m);
      chk(rq.size(), n + 1);
      for (int i = 0; i < n; i++)
         chk(rq[i + 1] & m, xp[i] & m);
   endtask

   sdb_column_engine i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid), .s_axi_wready(),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
      .sd_cmd(cmd), .byte_mask_pins(bmask), .dq_in(dqi),
      .dq_out(dqo), .dq_oe_n(oe_n));
   sdb_ctl_model i_ctl (
      .aclk(aclk), .sd_cmd(cmd), .byte_mask_pins(bmask), .dq_in(dqi));

   initial begin
      drv = 2'b00;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rchk(8'h00, 32'h0000_0020, 2'h0);
      rchk(8'hF0, 32'h0000_0000, 2'h2);
      wchk(8'hF0, 32'h0000_0000, 2'h2);
      wchk(8'h00, 32'h0000_0022, 2'h0);
      i_ctl.cyc(`SDB_CMD_ACT, 12'h4AB, 2'b00, ~dqi);
      i_ctl.rest(3, 2'b00);
      rchk(8'h08, 32'h0000_04AB, 2'h0);
      wd = '{16'hA000, 16'hA001, 16'hA002, 16'hA003};
      wr_burst(12'h001, 4, 9, 1'b0);
      xp = wd;
      rd_burst(12'h001, 4, 1'b0, 2'b00);
      words(4, 16'hFFFF);
      wchk(8'h00, 32'h0000_003A, 2'h0);
      xp = '{16'hA000, 16'hA003, 16'hA002, 16'hA001};
      rd_burst(12'h301, 4, 1'b0, 2'b00);
      words(4, 16'hFFFF);
      wchk(8'h00, 32'h0000_0022, 2'h0);
      wd = '{16'hB000, 16'hB001, 16'hB002, 16'hB003};
      wr_burst(12'h000, 4, 2, 1'b0);
      xp = '{16'hB000, 16'hB001, 16'hA002, 16'hB003};
      rd_burst(12'h000, 4, 1'b0, 2'b01);
      words(4, 16'hFF00);
      chk(drv, 2'b10);
      wchk(8'h00, 32'h0000_0222, 2'h0);
      wd = '{16'hC000, 16'hC001, 16'hC002, 16'hC003};
      wr_burst(12'h000, 4, 9, 1'b0);
      xp = '{16'hC000, 16'hB001, 16'hA002, 16'hB003};
      rd_burst(12'h000, 4, 1'b0, 2'b00);
      words(4, 16'hFFFF);
      wchk(8'h00, 32'h0000_0027, 2'h0);
      wd = '{16'hD000, 16'hD001, 16'hD002};
      wr_burst(12'h0FE, 3, 9, 1'b1);
      xp = wd;
      rd_burst(12'h4FE, 3, 1'b1, 2'b00);
      words(3, 16'hFFFF);
      rchk(8'h04, 32'h0000_0001, 2'h0);
      wchk(8'h00, 32'h0000_0022, 2'h0);
      // the page write wrapped onto column 0
      xp = '{16'hD002, 16'hB001, 16'hA002, 16'hB003};
      rd_burst(12'h400, 4, 1'b0, 2'b00);
      words(4, 16'hFFFF);
      rchk(8'h04, 32'h0000_0000, 2'h0);
      rd_burst(12'h000, 1, 1'b0, 2'b00);
      chk(rq.size(), 0);
      i_ctl.cyc(`SDB_CMD_ACT, 12'h000, 2'b00, ~dqi);
      i_ctl.cyc(`SDB_CMD_ACT, 12'h923, 2'b00, ~dqi);
      i_ctl.rest(3, 2'b00);
      rchk(8'h0C, 32'h0000_0123, 2'h0);
      rchk(8'h04, 32'h0000_0003, 2'h0);
      // two sync stages plus two precharge cycles before idle shows
      i_ctl.cyc(`SDB_CMD_PRE, 12'h800, 2'b00, ~dqi);
      i_ctl.rest(5, 2'b00);
      rchk(8'h04, 32'h0000_0001, 2'h0);
      i_ctl.cyc(`SDB_CMD_ACT, 12'h800, 2'b00, ~dqi);
      i_ctl.cyc(`SDB_CMD_PRE, 12'h400, 2'b00, ~dqi);
      i_ctl.rest(5, 2'b00);
      rchk(8'h04, 32'h0000_0000, 2'h0);
      give_verdict;
   end
endmodule // sdb_column_engine_tb

// ===== dv/sdb_ctl_model.sv
// sdram controller model: each cyc or stop call drives one clock of command, mask
// and write data; the bench orders the calls and keeps the spacing.
`timescale 1ns/1ps
`include "sdb_defs.svh"
module sdb_ctl_model
   import sdb_pkg::*;
(
   // clock
   input  wire logic   aclk,
   // controller pins
   output sdb_cmd_s    sd_cmd,
   output logic [1:0]  byte_mask_pins,
   output logic [15:0] dq_in
);
   initial begin
      sd_cmd = {4'hF, 12'h000};
      byte_mask_pins = 2'b00;
      dq_in = 16'h0000;
   end
   // callers need not open a bank first; the bench also reads an idle bank
   task automatic cyc(input logic [3:0] c, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
      @(posedge aclk);
      sd_cmd <= {c, a};
      byte_mask_pins <= m;
      dq_in <= d;
   endtask
   // released data lines flip so a stale word never looks valid
   task automatic rest(input int n, input logic [1:0] m);
      repeat (n) cyc(4'hF, 12'h000, m, ~dq_in);
   endtask
   task automatic stop(input logic [1:0] m);
      cyc(`SDB_CMD_BST, 12'h000, m, ~dq_in);
   endtask
endmodule // sdb_ctl_model

// ===== rtl/sdb_col_order.sv
// column order generator: beat index to column within the burst.
// purely combinational; the caller holds start column and index.
`timescale 1ns/1ps
module sdb_col_order
   import sdb_pkg::*;
(
   // burst
   input  wire logic [7:0] start,
   input  wire logic [7:0] idx,
   // mode
   input  wire logic [2:0] bl,
   input  wire logic       interleave,
   input  wire logic       single,
   // result
   output logic      [7:0] col,
   output logic      [7:0] blk_mask,
   output logic            last
);
   wire logic       full   = (bl == `SDB_BL_FULL) && !single;
   wire logic [7:0] mask_w =
      single              ? 8'h00 :
      (bl == `SDB_BL_2)   ? 8'h01 :
      (bl == `SDB_BL_4)   ? 8'h03 :
      (bl == `SDB_BL_8)   ? 8'h07 :
      full                ? 8'hFF : 8'h00;
   // full page ignores the interleave bit
   wire logic       use_x  = interleave && !full;
   wire logic [7:0] seq_c  = start + idx;
   wire logic [7:0] mix_c  = use_x ? (start ^ idx) : seq_c;

   assign blk_mask = mask_w;
   assign col      = (start & ~mask_w) | (mix_c & mask_w);
   // a page burst never ends by itself
   assign last     = !full && (idx == mask_w);
endmodule // sdb_col_order

// ===== rtl/sdb_column_engine.sv
// burst read/write column engine of a two-bank 16-bit sdram, plus an
// axi4-lite slave holding the mode word and showing bank state.
// assumes the sdram clock equals aclk; pins are still resynchronised,
// so every pin-relative timing is shifted by the two sync stages.
`timescale 1ns/1ps
module sdb_column_engine
   import sdb_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // sdram pins
   input  wire sdb_cmd_s    sd_cmd,
   input  wire logic [1:0]  byte_mask_pins,
   input  wire logic [15:0] dq_in,
   output logic [15:0]      dq_out,
   output logic [1:0]       dq_oe_n
);
   sdb_cmd_s    cmd_m;
   sdb_cmd_s    cmd;
   logic [1:0]  mask_m;
   logic [1:0]  mask_s;
   logic [15:0] dq_m;
   logic [15:0] dq_s;
   logic [9:0]  mode_q;
   sdb_mode_s   mode;
   sdb_bank_e   bank_st [2];
   logic [10:0] row_q   [2];
   logic [3:0]  pre_cnt [2];
   sdb_burst_e  eng_kind;
   logic        eng_bank;
   logic [7:0]  eng_start;
   logic [7:0]  eng_idx;
   logic        eng_ap;
   logic [15:0] rd_s0;
   logic [15:0] rd_s1;
   logic        v0;
   logic        v1;
   logic        vout;
   logic        vpre;
   logic        v0_or_out;
   logic [1:0]  mask_d1;
   logic [1:0]  mask_d2;
   logic [1:0]  wr_en;
   logic [1:0]  ap_fire;
   logic [1:0]  act_map;
   logic [1:0]  pre_map;
   logic [7:0]  beat_col;
   logic [7:0]  blk_mask;
   logic        beat_last;

   // pin synchronisers: first stage read only by the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_m  <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                     addr: 12'h000};
         cmd    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                     addr: 12'h000};
         mask_m <= 2'h0;
         mask_s <= 2'h0;
         dq_m   <= 16'h0000;
         dq_s   <= 16'h0000;
      end else begin
         cmd_m  <= sd_cmd;
         cmd    <= cmd_m;
         mask_m <= byte_mask_pins;
         mask_s <= mask_m;
         dq_m   <= dq_in;
         dq_s   <= dq_m;
      end
   end

   // command decode
   wire logic [3:0] cmd_code = {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n};
   wire logic is_act  = (cmd_code == `SDB_CMD_ACT);
   wire logic is_rd   = (cmd_code == `SDB_CMD_RD);
   wire logic is_wr   = (cmd_code == `SDB_CMD_WR);
   wire logic is_pre  = (cmd_code == `SDB_CMD_PRE);
   wire logic is_bst  = (cmd_code == `SDB_CMD_BST);
   wire logic cmd_bank = cmd.addr[`SDB_BANK_BIT];
   wire logic full    = (mode.bl == `SDB_BL_FULL);
   wire logic cl3     = (mode.cl == `SDB_CL_3);
   // column commands to an idle bank are dropped
   wire logic bank_ok = (bank_st[cmd_bank] == BANK_ACTIVE);
   wire logic rd_go   = is_rd && bank_ok;
   wire logic wr_go   = is_wr && bank_ok;
   wire logic go      = rd_go || wr_go;
   wire logic pre_hit = is_pre && (cmd.addr[`SDB_SCOPE_BIT]
                        || (cmd_bank == eng_bank));
   // burst stop or precharge of the bank ends the burst at once
   wire logic stop    = is_bst || pre_hit;

   // current beat: a new command overrides the running burst
   wire sdb_burst_e beat_kind = rd_go ? BURST_READ :
                                wr_go ? BURST_WRITE :
                                stop  ? BURST_NONE : eng_kind;
   wire logic       beat_rd    = (beat_kind == BURST_READ);
   wire logic       beat_wr    = (beat_kind == BURST_WRITE);
   wire logic       beat_bank  = go ? cmd_bank : eng_bank;
   wire logic [7:0] beat_start = go ? cmd.addr[7:0] : eng_start;
   wire logic [7:0] beat_idx   = go ? 8'h00 : eng_idx;
   wire logic       beat_ap    = go ? (cmd.addr[`SDB_AP_BIT] && !full)
                                    : eng_ap;
   wire logic [8:0] mem_addr   = {beat_bank, beat_col};

   sdb_col_order u_order (
      .start      (beat_start),
      .idx        (beat_idx),
      .bl         (mode.bl),
      .interleave (mode.interleave),
      .single     (beat_wr && mode.write_single),
      .col        (beat_col),
      .blk_mask   (blk_mask),
      .last       (beat_last)
   );

   // burst counter; the index rolls over modulo 256 in page mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         eng_kind  <= BURST_NONE;
         eng_bank  <= 1'b0;
         eng_start <= 8'h00;
         eng_idx   <= 8'h00;
         eng_ap    <= 1'b0;
      end else begin
         eng_kind  <= beat_last ? BURST_NONE : beat_kind;
         eng_bank  <= beat_bank;
         eng_start <= beat_start;
         eng_idx   <= beat_idx + 8'h01;
         eng_ap    <= beat_ap;
      end
   end

   // banks: independent idle/active/precharge, timed precharge
   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_bank
         assign ap_fire[b] = beat_rd && beat_last && beat_ap
                             && (beat_bank == b);
         assign act_map[b] = (bank_st[b] == BANK_ACTIVE);
         assign pre_map[b] = (bank_st[b] == BANK_PRECHARGE);
         wire logic act_hit = is_act && (cmd.addr[`SDB_BANK_BIT] == b)
                              && (bank_st[b] == BANK_IDLE);
         wire logic pre_cmd = is_pre && (cmd.addr[`SDB_SCOPE_BIT]
                              || (cmd.addr[`SDB_BANK_BIT] == b));
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               bank_st[b] <= BANK_IDLE;
               row_q[b]   <= 11'h000;
               pre_cnt[b] <= 4'h0;
            end else if (act_hit) begin
               bank_st[b] <= BANK_ACTIVE;
               row_q[b]   <= cmd.addr[10:0];
            end else if ((pre_cmd || ap_fire[b])
                         && bank_st[b] == BANK_ACTIVE) begin
               bank_st[b] <= BANK_PRECHARGE;
               pre_cnt[b] <= 4'(`SDB_ROW_PRE_CYC - 1);
            end else if (bank_st[b] == BANK_PRECHARGE) begin
               if (pre_cnt[b] == 4'h0) begin
                  bank_st[b] <= BANK_IDLE;
               end
               pre_cnt[b] <= pre_cnt[b] - 4'h1;
            end
         end
      end
   endgenerate

   // array of the open columns, one byte lane per generate pass;
   // rows are tracked but not stored, a deliberate size trade-off
   genvar l;
   generate
      for (l = 0; l < 2; l++) begin : g_lane
         logic [7:0] mem [0:511];
         // write data has no latency; mask blocks the byte now
         assign wr_en[l] = beat_wr && !mask_s[l];
         always_ff @(posedge aclk) begin
            if (wr_en[l]) begin
               mem[mem_addr] <= dq_s[8*l +: 8];
            end
         end
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               rd_s0[8*l +: 8] <= 8'h00;
            end else begin
               rd_s0[8*l +: 8] <= mem[mem_addr];
            end
         end
         // read mask disables the byte two clocks later
         assign dq_oe_n[l] = !(v0_or_out) || mask_d2[l];
      end
   endgenerate

   // read pipe: output register picks the tap for the latency
   assign vpre      = cl3 ? v1 : v0;
   assign v0_or_out = vpre || vout;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         v0      <= 1'b0;
         v1      <= 1'b0;
         vout    <= 1'b0;
         rd_s1   <= 16'h0000;
         dq_out  <= 16'h0000;
         mask_d1 <= 2'h0;
         mask_d2 <= 2'h0;
      end else begin
         v0      <= beat_rd;
         v1      <= v0;
         vout    <= vpre;
         rd_s1   <= rd_s0;
         dq_out  <= cl3 ? rd_s1 : rd_s0;
         mask_d1 <= mask_s;
         mask_d2 <= mask_d1;
      end
   end

   // axi4-lite slave: one write and one read outstanding
   wire logic wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   wire logic rd_take = s_axi_arvalid && !s_axi_rvalid;
   wire logic aw_mode = (s_axi_awaddr == `SDB_OFF_MODE);
   wire logic aw_hit  = aw_mode || (s_axi_awaddr == `SDB_OFF_STATUS)
                        || (s_axi_awaddr == `SDB_OFF_ROW0)
                        || (s_axi_awaddr == `SDB_OFF_ROW1);
   wire logic [31:0] status_w = {26'h000_0000,
                                 eng_kind == BURST_WRITE,
                                 eng_kind == BURST_READ,
                                 pre_map, act_map};
   wire logic [31:0] rd_mux =
      (s_axi_araddr == `SDB_OFF_MODE)   ? {22'h00_0000, mode_q} :
      (s_axi_araddr == `SDB_OFF_STATUS) ? status_w :
      (s_axi_araddr == `SDB_OFF_ROW0)   ? {21'h00_0000, row_q[0]} :
      (s_axi_araddr == `SDB_OFF_ROW1)   ? {21'h00_0000, row_q[1]} :
                                          32'h0000_0000;
   wire logic ar_hit = (s_axi_araddr == `SDB_OFF_MODE)
                       || (s_axi_araddr == `SDB_OFF_STATUS)
                       || (s_axi_araddr == `SDB_OFF_ROW0)
                       || (s_axi_araddr == `SDB_OFF_ROW1);
   wire logic [9:0] wr_bits =
      {s_axi_wstrb[1] ? s_axi_wdata[9:8] : mode_q[9:8],
       s_axi_wstrb[0] ? s_axi_wdata[7:0] : mode_q[7:0]};

   assign s_axi_awready = wr_take;
   assign s_axi_wready  = wr_take;
   assign s_axi_arready = rd_take;
   assign mode = '{write_single: mode_q[`SDB_MODE_WS_BIT],
                   cl:           mode_q[`SDB_MODE_CL_LSB +: 3],
                   interleave:   mode_q[`SDB_MODE_BT_BIT],
                   bl:           mode_q[`SDB_MODE_BL_LSB +: 3]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q       <= `SDB_MODE_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `SDB_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `SDB_RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
      end else begin
         if (wr_take && aw_mode) begin
            mode_q <= wr_bits & `SDB_MODE_WMASK;
         end
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aw_hit ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ar_hit ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd_first;
      beat_rd && beat_idx == 8'h00;
   endsequence
   sequence s_ap_last;
      beat_rd && beat_last && beat_ap;
   endsequence

   a_order_block: assert property (beat_kind != BURST_NONE |->
      (beat_col & ~blk_mask) == (beat_start & ~blk_mask))
      else $error("burst column left its aligned block");
   a_order_xor: assert property (beat_rd && beat_idx == 8'h01
      && mode.interleave && blk_mask != 8'h00 && !full
      |-> beat_col == (beat_start ^ 8'h01))
      else $error("interleaved second column wrong");
   a_page_step: assert property (eng_kind == BURST_READ && full
      && !stop && !go |=> go || beat_col == 8'($past(beat_col) + 8'h01))
      else $error("page burst did not step by one");
   a_scope_both: assert property (is_pre && cmd.addr[`SDB_SCOPE_BIT]
      |=> act_map == 2'b00)
      else $error("precharge all left a bank active");
   a_bank_open: assert property (is_act && !cmd.addr[`SDB_BANK_BIT]
      && bank_st[0] == BANK_IDLE |=> act_map[0]
      && row_q[0] == $past(cmd.addr[10:0]))
      else $error("activate did not open bank 0");
   a_col_start: assert property (go |-> beat_col == cmd.addr[7:0]
      && beat_bank == cmd.addr[`SDB_BANK_BIT])
      else $error("burst did not start at given column");
   a_lead_cl2: assert property (s_rd_first ##0 !cl3
      |-> ##1 v0_or_out ##1 vout)
      else $error("latency two output timing wrong");
   a_lead_cl3: assert property (s_rd_first ##0 cl3
      |-> ##2 v0_or_out ##1 vout)
      else $error("latency three output timing wrong");
   a_read_hiz: assert property ((beat_rd && beat_last && !cl3)
      ##1 (!beat_rd) [*2] |=> !v0_or_out)
      else $error("outputs stayed on after the burst");
   a_rmask_two: assert property (mask_s[1] |-> ##2 dq_oe_n[1])
      else $error("read mask not applied after two clocks");
   a_wr_first: assert property (wr_go |-> wr_en == ~mask_s)
      else $error("first write word not taken with command");
   a_wr_end: assert property ((beat_wr && beat_last) ##1 !go
      |-> !beat_wr)
      else $error("write burst ran past its length");
   a_wmask_now: assert property (beat_wr && mask_s[0] |-> !wr_en[0])
      else $error("masked write byte was written");
   a_ap_cl2: assert property (s_ap_last ##0 !cl3
      |=> pre_map[$past(beat_bank)] ##1 vout)
      else $error("latency two auto-precharge lead wrong");
   a_ap_cl3: assert property (s_ap_last ##0 cl3
      |=> pre_map[$past(beat_bank)] ##2 vout)
      else $error("latency three auto-precharge lead wrong");
   a_ap_idle: assert property (ap_fire[0]
      |=> pre_map[0] ##[1:16] bank_st[0] == BANK_IDLE)
      else $error("auto-precharged bank never went idle");
   a_page_no_ap: assert property (full |-> ap_fire == 2'b00)
      else $error("auto-precharge in page mode");
   a_single_wr: assert property (beat_wr && mode.write_single
      |-> beat_last)
      else $error("single write ran a burst");
endmodule // sdb_column_engine

// ===== rtl/sdb_defs.svh
// register offsets, field positions, reset values and timing counts for
// the sdram burst column engine; included by the package, the bench and the controller model.
`ifndef SDB_DEFS_SVH
`define SDB_DEFS_SVH

`define SDB_OFF_MODE       8'h00
`define SDB_OFF_STATUS     8'h04
`define SDB_OFF_ROW0       8'h08
`define SDB_OFF_ROW1       8'h0C

`define SDB_MODE_BL_LSB    0
`define SDB_MODE_BT_BIT    3
`define SDB_MODE_CL_LSB    4
`define SDB_MODE_WS_BIT    9
`define SDB_MODE_RESET     10'h020
`define SDB_MODE_WMASK     10'h27F

`define SDB_BL_1           3'h0
`define SDB_BL_2           3'h1
`define SDB_BL_4           3'h2
`define SDB_BL_8           3'h3
`define SDB_BL_FULL        3'h7
`define SDB_CL_3           3'h3

`define SDB_CMD_ACT        4'h3
`define SDB_CMD_RD         4'h5
`define SDB_CMD_WR         4'h4
`define SDB_CMD_PRE        4'h2
`define SDB_CMD_BST        4'h6

`define SDB_SCOPE_BIT      10
`define SDB_AP_BIT         10
`define SDB_BANK_BIT       11

`define SDB_RESP_OKAY      2'h0
`define SDB_RESP_SLVERR    2'h2

`define SDB_CLK_NS         10
`define SDB_ROW_PRE_NS     20
`define SDB_ROW_PRE_CYC    \
   ((`SDB_ROW_PRE_NS + `SDB_CLK_NS - 1) / `SDB_CLK_NS)

`endif

// ===== rtl/sdb_pkg.sv
// types shared by the sdram burst column engine.
// assumes sdb_defs.svh is on the include path.
package sdb_pkg;
   `include "sdb_defs.svh"

   typedef struct packed {
      logic        cs_n;
      logic        ras_n;
      logic        cas_n;
      logic        we_n;
      logic [11:0] addr;
   } sdb_cmd_s;

   typedef struct packed {
      logic       write_single;
      logic [2:0] cl;
      logic       interleave;
      logic [2:0] bl;
   } sdb_mode_s;

   typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_PRECHARGE} sdb_bank_e;
   typedef enum logic [1:0] {BURST_NONE, BURST_READ, BURST_WRITE} sdb_burst_e;
endpackage
